//--- rtl/dmc_pkg.sv
// Purpose: Shared constants and types for the mode-control block
// Assumes: 8-bit registers addressed by a 7-bit index
// Notes: Control words arrive already deserialised as 16-bit words
package dmc_pkg;
	// Control word layout
	localparam int WORD_W = 16;
	localparam int IDX_MSB = 14;
	localparam int IDX_LSB = 8;
	localparam int ZERO_BIT = 15;
	// Register indices
	localparam logic [6:0] IDX_LEFT_LEVEL = 7'h01;
	localparam logic [6:0] IDX_RIGHT_LEVEL = 7'h02;
	localparam logic [6:0] IDX_FORMAT = 7'h03;
	localparam logic [6:0] IDX_POWER = 7'h04;
	// Field positions, format register
	localparam int POS_RIGHT_POLARITY_INVERT = 5;
	localparam int POS_ANALOG_MIX_ENABLE = 4;
	localparam int POS_DEEMPH = 3;
	localparam int POS_FMT = 0;
	// Field positions, power register; the mute bits sit in the left level register
	localparam int POS_ZCROSS = 4;
	localparam int POS_PWRDN = 0;
	localparam int POS_MUTE = 6;
	localparam int POS_MUTE_RIGHT = 7;
	// Reset values
	localparam logic [7:0] RST_FORMAT = 8'h00;
	localparam logic [7:0] RST_POWER = 8'h00;
	localparam logic [7:0] RST_LEVEL = 8'h3F;
	// Timing in sample periods
	localparam int STEP_SAMPLES = 8;
	localparam int ZC_TIMEOUT_SAMPLES = 512;
	// Audio formats
	typedef enum logic [2:0] {
		FMT_LJ = 3'h0, FMT_I2S = 3'h1, FMT_RJ24 = 3'h2,
		FMT_RJ20 = 3'h3, FMT_RJ16 = 3'h4, FMT_LJ_MASTER = 3'h5
	} dmc_format_e;
	// Mode outputs bundled together
	typedef struct packed {
		logic rightInvert;
		logic analogMix;
		logic deemphasis;
		logic [2:0] audioFormat;
		logic zeroCross;
		logic powerDown;
	} dmc_mode_s;
endpackage

//--- rtl/dmc_level_stepper.sv
// Purpose: One-channel attenuator stepping toward its target
// Assumes: sampleTick pulses once per sample period
// Notes: Zero-cross wait is bounded by a timeout
`timescale 1ns/1ns
`default_nettype none
module dmc_level_stepper
	import dmc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic clear,
	// Control
	input wire logic sampleTick,
	input wire logic stepSlot,
	input wire logic zeroCross,
	input wire logic crossing,
	input wire logic [5:0] target,
	// Status
	output logic [5:0] level,
	output logic stepped
);
	//------------------------------
	// Step pacing
	//------------------------------
	logic [5:0] level_reg, level_next;
	logic [2:0] pace_reg; // Counts sample periods between steps
	logic [9:0] wait_reg; // Samples spent waiting for a crossing
	logic due_reg; // Step slot reached, step not yet taken
	logic pending;
	wire logic paceDone = sampleTick && (pace_reg == 3'(STEP_SAMPLES - 1));
	wire logic timedOut = (wait_reg >= 10'(ZC_TIMEOUT_SAMPLES));
	wire logic zcOk = !zeroCross || crossing || timedOut;
	wire logic doStep = due_reg && pending && stepSlot && zcOk;
	assign pending = (level_reg != target);
	assign level_next = (target > level_reg) ? level_reg + 6'h01 : level_reg - 6'h01;
	assign level = level_reg;
	assign stepped = doStep;
	// Level register, step flag and counters
	always_ff @(posedge clk) begin
		if (!resetn || clear) begin
			level_reg <= RST_LEVEL[5:0];
			pace_reg <= 3'h0;
			wait_reg <= 10'h000;
			due_reg <= 1'b0;
		end else begin
			if (sampleTick) begin
				pace_reg <= pace_reg + 3'h1;
			end
			if (doStep) begin
				level_reg <= level_next;
			end
			// A slot missed while waiting is absorbed, not queued
			if (doStep || !pending) begin
				due_reg <= 1'b0;
			end else if (paceDone) begin
				due_reg <= 1'b1;
			end
			// Wait counts samples only while a due step is held back
			if (doStep || !due_reg) begin
				wait_reg <= 10'h000;
			end else if (sampleTick && zeroCross && !timedOut) begin
				wait_reg <= wait_reg + 10'h001;
			end
		end
	end
	//------------------------------
	// Checks
	//------------------------------
	property p_one_db_step;
		@(posedge clk) disable iff (!resetn || clear)
		doStep |=> ((level_reg - $past(level_reg)) == 6'h01) ||
			(($past(level_reg) - level_reg) == 6'h01);
	endproperty
	a_one_db_step: assert property (p_one_db_step) else $error("Step not 1 dB");
	property p_timeout_bound;
		@(posedge clk) disable iff (!resetn || clear)
		wait_reg <= 10'(ZC_TIMEOUT_SAMPLES);
	endproperty
	a_timeout_bound: assert property (p_timeout_bound) else $error("Wait overran");
endmodule
`default_nettype wire

//--- rtl/dmc_mode_control.sv
// Purpose: Mode registers and attenuator control of a stereo DAC
// Assumes: Control words arrive as one-cycle strobes with 16-bit data
// Notes: Power-down clears datapath state but keeps registers
//
// Notes on behaviour
// - Polarity bit set inverts right output
// - Mix bit set sums analog input
// - De-emphasis bit enables 44.1 kHz filter
// - Three-bit field selects serial audio format
// - Zero-cross bit defers steps to crossings
// - No crossing in 512 samples: step anyway
// - Per-channel detection, steps alternate channels
// - Power-down bit enters low-power state
// - Power-down resets logic, keeps registers
// - Power-down bit never resets registers
// - Attenuator moves 1 dB per eight samples
// - Word: bit15 zero, index, eight data
`timescale 1ns/1ns
`default_nettype none
module dmc_mode_control
	import dmc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control word port
	input wire logic wordValid,
	input wire logic [15:0] controlWord,
	// Sample timing and signal zero crossings
	input wire logic sampleTick,
	input wire logic leftCrossing,
	input wire logic rightCrossing,
	// Mode outputs
	output dmc_mode_s mode,
	output logic [5:0] leftLevel,
	output logic [5:0] rightLevel,
	output logic datapathReset
);
	//------------------------------
	// Word decode
	//------------------------------
	wire logic [6:0] registerIndex = controlWord[IDX_MSB:IDX_LSB];
	wire logic [7:0] wordData = controlWord[7:0];
	wire logic wordOk = wordValid && !controlWord[ZERO_BIT];
	wire logic wrLeft = wordOk && (registerIndex == IDX_LEFT_LEVEL);
	wire logic wrRight = wordOk && (registerIndex == IDX_RIGHT_LEVEL);
	wire logic wrFormat = wordOk && (registerIndex == IDX_FORMAT);
	wire logic wrPower = wordOk && (registerIndex == IDX_POWER);
	// Other indices fall through every decode above
	//------------------------------
	// Registers
	//------------------------------
	logic [7:0] left_reg; // Left target and mute
	logic [7:0] right_reg; // Right target
	logic [7:0] format_reg; // Format and options
	logic [7:0] power_reg; // Zero cross and power
	// Register writes, reset only by resetn
	always_ff @(posedge clk) begin
		if (!resetn) begin
			left_reg <= RST_LEVEL;
			right_reg <= RST_LEVEL;
			format_reg <= RST_FORMAT;
			power_reg <= RST_POWER;
		end else begin
			if (wrLeft) begin
				left_reg <= wordData;
			end
			if (wrRight) begin
				right_reg <= wordData;
			end
			if (wrFormat) begin
				format_reg <= wordData;
			end
			if (wrPower) begin
				power_reg <= wordData;
			end
		end
	end
	//------------------------------
	// Mode outputs
	//------------------------------
	// Reserved format codes read back as the default format
	wire logic [2:0] rawFormat = format_reg[POS_FMT +: 3];
	wire logic fmtReserved = (rawFormat > 3'(FMT_LJ_MASTER));
	wire logic pwrDown = power_reg[POS_PWRDN];
	assign mode.rightInvert = format_reg[POS_RIGHT_POLARITY_INVERT];
	assign mode.analogMix = format_reg[POS_ANALOG_MIX_ENABLE];
	assign mode.deemphasis = format_reg[POS_DEEMPH];
	assign mode.audioFormat = fmtReserved ? 3'(FMT_LJ) : rawFormat;
	assign mode.zeroCross = power_reg[POS_ZCROSS];
	assign mode.powerDown = pwrDown;
	assign datapathReset = pwrDown;
	//------------------------------
	// Attenuators
	//------------------------------
	logic turn_reg; // Which channel may step next
	logic [1:0] stepped;
	logic [1:0] crossing;
	logic [5:0] target [2];
	logic [5:0] level [2];
	// Both mute bits sit in the left level register
	wire logic mutedLeft = left_reg[POS_MUTE];
	wire logic mutedRight = left_reg[POS_MUTE_RIGHT];
	assign crossing = {rightCrossing, leftCrossing};
	assign target[0] = mutedLeft ? 6'h00 : left_reg[5:0];
	assign target[1] = mutedRight ? 6'h00 : right_reg[5:0];
	// Turn passes after a step so channels alternate
	always_ff @(posedge clk) begin
		if (!resetn || pwrDown) begin
			turn_reg <= 1'b0;
		end else if (|stepped) begin
			turn_reg <= ~turn_reg;
		end
	end
	// One stepper per channel, left is index 0
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			// Step slot: own turn, or other side idle
			wire logic slot = (turn_reg == 1'(ch)) ||
				(level[1 - ch] == target[1 - ch]);
			dmc_level_stepper u_step (
				.clk(clk),
				.resetn(resetn),
				.clear(pwrDown),
				.sampleTick(sampleTick),
				.stepSlot(slot),
				.zeroCross(mode.zeroCross),
				.crossing(crossing[ch]),
				.target(target[ch]),
				.level(level[ch]),
				.stepped(stepped[ch])
			);
		end
	endgenerate
	// Channel levels out to the ports
	assign leftLevel = level[0];
	assign rightLevel = level[1];
	//------------------------------
	// Checks
	//------------------------------
	// Format register holds through power-down unless written
	property p_pd_keeps_regs;
		@(posedge clk) disable iff (!resetn)
		(pwrDown && !wordOk) |=> (format_reg == $past(format_reg));
	endproperty
	a_pd_keeps_regs: assert property (p_pd_keeps_regs) else $error("Regs lost");
	// Format write lands on the next cycle
	property p_format_write;
		@(posedge clk) disable iff (!resetn)
		wrFormat |=> (format_reg == $past(wordData));
	endproperty
	a_format_write: assert property (p_format_write) else $error("Format lost");
	// Index above IDX_POWER leaves the power register alone
	property p_bad_index;
		@(posedge clk) disable iff (!resetn)
		(wordValid && registerIndex > IDX_POWER) |=> $stable(power_reg);
	endproperty
	a_bad_index: assert property (p_bad_index) else $error("Bad write");
	// Marker bit set refuses the word
	property p_bit15;
		@(posedge clk) disable iff (!resetn)
		(wordValid && controlWord[ZERO_BIT]) |=> $stable(format_reg);
	endproperty
	a_bit15: assert property (p_bit15) else $error("Bit15 taken");
	// Power-down returns both levels to their reset value
	property p_pd_clears;
		@(posedge clk) disable iff (!resetn)
		pwrDown |=> (leftLevel == RST_LEVEL[5:0]) && (rightLevel == RST_LEVEL[5:0]);
	endproperty
	a_pd_clears: assert property (p_pd_clears) else $error("No clear");
	// Reserved codes show as the default format
	property p_reserved_fmt;
		@(posedge clk) disable iff (!resetn)
		fmtReserved |-> (mode.audioFormat == 3'h0);
	endproperty
	a_reserved_fmt: assert property (p_reserved_fmt) else $error("Fmt");
	// Never both channels in one cycle
	property p_alternate;
		@(posedge clk) disable iff (!resetn)
		(&stepped) |-> 1'b0;
	endproperty
	a_alternate: assert property (p_alternate) else $error("Both");
	// Polarity bit follows the written word
	property p_invert;
		@(posedge clk) disable iff (!resetn)
		wrFormat |=> (mode.rightInvert == $past(wordData[POS_RIGHT_POLARITY_INVERT]));
	endproperty
	a_invert: assert property (p_invert) else $error("Invert");
	// Mix and de-emphasis bits follow the written word
	property p_option_write;
		@(posedge clk) disable iff (!resetn)
		wrFormat |=> (mode.analogMix == $past(wordData[POS_ANALOG_MIX_ENABLE])) &&
			(mode.deemphasis == $past(wordData[POS_DEEMPH]));
	endproperty
	a_option_write: assert property (p_option_write) else $error("Option lost");
	// Power register write lands on the next cycle
	property p_power_write;
		@(posedge clk) disable iff (!resetn)
		wrPower |=> (mode.zeroCross == $past(wordData[POS_ZCROSS])) &&
			(mode.powerDown == $past(wordData[POS_PWRDN]));
	endproperty
	a_power_write: assert property (p_power_write) else $error("Power lost");
	// Power-down also resets the channel turn
	property p_pd_turn;
		@(posedge clk) disable iff (!resetn)
		pwrDown |=> !turn_reg;
	endproperty
	a_pd_turn: assert property (p_pd_turn) else $error("Turn kept");
	// Levels only move on a granted step
	property p_level_holds;
		@(posedge clk) disable iff (!resetn || pwrDown)
		!(|stepped) |=> ($stable(leftLevel) && $stable(rightLevel));
	endproperty
	a_level_holds: assert property (p_level_holds) else $error("Level moved");
	// Main scenarios
	c_pd: cover property (@(posedge clk) wrPower ##1 pwrDown);
	c_step: cover property (@(posedge clk) stepped[0] ##[1:20] stepped[1]);
	c_fmt: cover property (@(posedge clk) wrFormat ##1 fmtReserved);
	c_refused: cover property (@(posedge clk) wordValid && !wordOk);
	c_mute: cover property (@(posedge clk) mutedRight && stepped[1]);
endmodule
`default_nettype wire

//--- sim/dmc_host_model.sv
// Purpose: Host side that writes control words into the block
// Assumes: Words are launched at falling edges, one strobe each
// Notes: Behavioural; writeFormat sends reserved data bits as zero, send passes words unchanged
`timescale 1ns/1ns
`default_nettype none
module dmc_host_model (
	// Clock
	input wire logic clk,
	// Control word port
	output logic wordValid,
	output logic [15:0] controlWord
);
	// Idle port shows junk, never a stale word
	initial begin
		wordValid = 1'b0;
		controlWord = 16'hFFFF;
	end
	// One-cycle strobe carrying one whole word
	task automatic send(input logic [15:0] w);
		@(negedge clk);
		wordValid = 1'b1;
		controlWord = w;
		@(negedge clk);
		wordValid = 1'b0;
		controlWord = ~w;
	endtask
	// Format register write with reserved bits zero
	task automatic writeFormat(input logic inv, input logic mix, input logic deemphasis_enable,
		input logic [2:0] fmt);
		send({8'h03, 2'b00, inv, mix, deemphasis_enable, fmt});
	endtask
endmodule
`default_nettype wire

//--- sim/dmc_mode_control_test.sv
// Purpose: Self-checking bench for the mode-control block
// Assumes: Inputs change at falling edges
// Notes: Sample ticks are one cycle wide, two cycles apart
`timescale 1ns/1ns
`default_nettype none
module dmc_mode_control_test;
	import dmc_pkg::*;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic clk, resetn, sampleTick, leftCrossing, rightCrossing;
	logic datapathReset;
	wire logic wordValid;
	wire logic [15:0] controlWord;
	dmc_mode_s mode;
	logic [5:0] leftLevel, rightLevel;
	int n_errors = 0, samples_checked = 0;
	// Host partner
	dmc_host_model host (.clk(clk), .wordValid(wordValid), .controlWord(controlWord));
	// Block under test
	dmc_mode_control uut (.clk(clk), .resetn(resetn), .wordValid(wordValid),
		.controlWord(controlWord), .sampleTick(sampleTick), .leftCrossing(leftCrossing),
		.rightCrossing(rightCrossing), .mode(mode), .leftLevel(leftLevel),
		.rightLevel(rightLevel), .datapathReset(datapathReset));
	// Clock, 10 ns period
	always #5 clk = ~clk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Value compare
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	// Sample periods, then one cycle to settle
	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge clk) sampleTick = 1'b1;
			@(negedge clk) sampleTick = 1'b0;
		end
		@(negedge clk);
	endtask
	// Verdict and end of run
	task automatic summarize();
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Every format code with all option bits set
	task automatic tFormat();
		for (int f = 0; f < 8; f++) begin
			host.writeFormat(1'b1, 1'b1, 1'b1, f[2:0]);
			@(negedge clk);
			chk("mode", {3'b111, (f < 6) ? f[2:0] : 3'h0, 2'b00}, mode);
		end
	endtask
	// Bad marker bit and unknown indices leave registers alone
	task automatic tRefused();
		host.send(16'h8312);
		host.send(16'h0512);
		host.send(16'h0012);
		@(negedge clk);
		chk("mode", 8'hE0, mode);
	endtask
	// Plain stepping, two counts
	task automatic tLevel();
		host.send(16'h013D);
		ticks(7);
		chk("leftLevel", 8'h3F, {2'b00, leftLevel});
		ticks(1);
		chk("leftLevel", 8'h3E, {2'b00, leftLevel});
		ticks(16);
		chk("leftLevel", 8'h3D, {2'b00, leftLevel});
		chk("rightLevel", 8'h3F, {2'b00, rightLevel});
	endtask
	// Zero-cross wait, timeout, then a real crossing
	task automatic tZeroCross();
		host.send(16'h0410);
		host.send(16'h023E);
		ticks(400);
		chk("rightLevel", 8'h3F, rightLevel);
		ticks(140);
		chk("rightLevel", 8'h3E, rightLevel);
		rightCrossing = 1'b1;
		host.send(16'h023D);
		ticks(16);
		chk("rightLevel", 8'h3D, rightLevel);
		rightCrossing = 1'b0;
		leftCrossing = 1'b1;
		host.send(16'h0139);
		host.send(16'h023C);
		ticks(16);
		chk("leftLevel", 8'h3C, {2'b00, leftLevel});
		chk("rightLevel", 8'h3D, {2'b00, rightLevel});
		rightCrossing = 1'b1;
		ticks(16);
		chk("leftLevel", 8'h39, {2'b00, leftLevel});
		chk("rightLevel", 8'h3C, {2'b00, rightLevel});
		leftCrossing = 1'b0;
		rightCrossing = 1'b0;
	endtask
	// Power-down clears levels, keeps registers
	task automatic tPowerDown();
		host.writeFormat(1'b0, 1'b1, 1'b0, 3'h2);
		host.send(16'h0401);
		@(negedge clk);
		chk("mode", 8'h49, mode);
		chk("datapathReset", 8'h01, {7'h00, datapathReset});
		chk("leftLevel", 8'h3F, {2'b00, leftLevel});
		chk("rightLevel", 8'h3F, {2'b00, rightLevel});
		host.send(16'h0400);
		@(negedge clk);
		chk("mode", 8'h48, mode);
		chk("datapathReset", 8'h00, {7'h00, datapathReset});
		ticks(8);
		chk("leftLevel", 8'h3E, {2'b00, leftLevel});
		chk("rightLevel", 8'h3F, {2'b00, rightLevel});
	endtask
	// Mid-run reset restores defaults, then right mute steps down
	task automatic tReset();
		resetn = 1'b0;
		@(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		chk("mode", 8'h00, mode);
		chk("leftLevel", 8'h3F, {2'b00, leftLevel});
		chk("rightLevel", 8'h3F, {2'b00, rightLevel});
		host.send(16'h0180);
		ticks(9);
		chk("leftLevel", 8'h3E, {2'b00, leftLevel});
		chk("rightLevel", 8'h3E, {2'b00, rightLevel});
	endtask
	// Main sequence
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		sampleTick = 1'b0;
		leftCrossing = 1'b0;
		rightCrossing = 1'b0;
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		chk("mode", 8'h00, mode);
		chk("leftLevel", 8'h3F, leftLevel);
		tFormat();
		tRefused();
		tLevel();
		tZeroCross();
		tPowerDown();
		tReset();
		summarize();
	end
	// Watchdog, well past the expected run
	initial begin
		#100000;
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire
